/* post_code_consts.svh */
`ifndef POST_CODE_CONSTS_SVH
`define POST_CODE_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets on the shared internal bus
// ----------------------------------------------------------------
`define OFS_HOST_DATA      12'h000
`define OFS_HOST_ALIAS     12'h004
`define OFS_EC_VALUE       12'h100
`define OFS_EC_STATUS      12'h104
`define OFS_EC_CONFIG      12'h108
`define OFS_EC_SNAPSHOT    12'h10c
`define OFS_CFG_ACTIVATE   12'h330
`define OFS_CFG_LANE       12'h3f0

// host configuration port indices, translated to the offsets above
`define IDX_CFG_ACTIVATE   8'h30
`define IDX_CFG_LANE       8'hf0

// ----------------------------------------------------------------
// sizes, field positions and reset values
// ----------------------------------------------------------------
`define FIFO_DEPTH         32
`define ENTRY_WIDTH        12
`define THRES_WIDTH        6
`define CFG_SOFT_RESET_BIT 7
`define STAT_IE_BIT        8
`define STAT_IE_LANE       1
`define THRES_RESET        6'h01
`define LANE_RESET         2'h0
`define LEN_BYTE           2'h0
`define LEN_WORD           2'h1
`define LEN_DWORD          2'h2
`define LEN_CONT           2'h3

`endif

/* post_code_pkg.sv */
package post_code_pkg;

    // one access on the shared internal bus
    typedef struct packed {
        logic        req;
        logic        wr;
        logic        ld1;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } bus_req_s;

    // one stored debug byte with its attributes
    typedef struct packed {
        logic [1:0] len;
        logic [1:0] lane;
        logic [7:0] value;
    } fifo_entry_s;

    // access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SPLIT,
        ST_GAP
    } ctl_state_e;

endpackage

/* post_code_fifo.sv */
`timescale 1ns/10ps

module post_code_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH),
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready,
    // fill level
    output logic [CW-1:0]         count,
    output logic                  full
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             push;
    logic             pop;

    // ----------------------------------------------------------------
    // handshake and status
    // ----------------------------------------------------------------
    // a full store still accepts when the drain side frees a slot
    assign full      = (count_r == CW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign in_ready  = !full || out_ready;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];
    assign count     = count_r;

    // pointer and level next values
    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (push) begin
            wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
        if (flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt  = '0;
        end
    end

    // pointer and level registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    // storage array, written without reset
    always_ff @(posedge sys_clk) begin
        if (push && !flush) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

endmodule

/* post_code_capture_port.sv */
// Summary of operation
// RQ1: thirty-two byte entry first-in first-out store
// RQ2: host writes split into bytes with attributes
// RQ3: host read of data returns zero
// RQ4: only controller pops, via value register
// RQ5: full write drops oldest, sets overrun
// RQ6: overrun clears when oldest surviving byte read
// RQ7: status readable with enable and attributes
// RQ8: every byte also lands in snapshot lane
// RQ9: snapshot updates once per host instruction
// RQ10: empty read keeps pointer, not-empty reads zero
// RQ11: interrupt at threshold, gated by two enables
// RQ12: soft reset bit and chip reset clear all
// RQ13: platform power resets leave contents intact
// RQ14: enable changes never flush the store
// RQ15: one shared bus, wait states interlock accesses
// RQ16: everything runs on the single block clock
// RQ17: base enable at index 30h, offset 330h
// RQ18: disabled base drops host data writes silently
// RQ19: alias byte steered by two-bit lane field
// RQ20: firmware clears interrupt by draining or reconfiguring
// RQ21: threshold is a plain configurable count field
`timescale 1ns/10ps
`include "post_code_consts.svh"

module post_code_capture_port (
    // clock and chip-wide reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // shared internal register bus
    input  wire post_code_pkg::bus_req_s bus_in,
    output logic                         bus_ready,
    output logic [31:0]                  bus_rdata,
    // controller interrupt
    output logic                         threshold_interrupt
);

    localparam int CW = $clog2(`FIFO_DEPTH + 1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    post_code_pkg::ctl_state_e     state_r, state_nxt;
    logic [3:0]                    pend_mask_r, pend_mask_nxt;
    logic [31:0]                   pend_data_r, pend_data_nxt;
    logic [1:0]                    size_r, size_nxt;
    logic                          first_r, first_nxt;
    logic [31:0]                   snap_r, snap_nxt;
    logic                          overrun_r, overrun_nxt;
    logic                          irq_en_r, irq_en_nxt;
    logic [`THRES_WIDTH-1:0]       thres_r, thres_nxt;
    logic                          act0_r, act0_nxt;
    logic                          act1_r, act1_nxt;
    logic [1:0]                    lane_r, lane_nxt;
    logic                          ready_r, ready_nxt;
    logic [31:0]                   rdata_r, rdata_nxt;
    logic                          irq_r, irq_nxt;
    // fifo side
    logic                          push;
    logic                          pop;
    logic                          soft_rst;
    post_code_pkg::fifo_entry_s    push_entry;
    post_code_pkg::fifo_entry_s    head_entry;
    logic                          fifo_valid;
    logic                          fifo_full;
    logic [CW-1:0]                 fifo_count;
    logic                          drop;
    logic                          threshold_status;
    logic                          take;

    // lowest pending lane of a host write
    function automatic logic [1:0] low_lane(input logic [3:0] m);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // length code of one host instruction from its lanes
    function automatic logic [1:0] size_code(input logic [3:0] m);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 4; i++) begin
            n = n + {2'h0, m[i]};
        end
        return (n == 3'h1) ? `LEN_BYTE : (n == 3'h2) ? `LEN_WORD : `LEN_DWORD;
    endfunction

    // ----------------------------------------------------------------
    // fifo and derived status
    // ----------------------------------------------------------------
    // RQ5 discard oldest on full
    assign drop       = push && fifo_full;
    // RQ11 count at or above threshold
    assign threshold_status = (fifo_count >= CW'(thres_r));
    assign take       = (state_r == post_code_pkg::ST_IDLE) && bus_in.req;

    // RQ1 thirty-two entry store
    post_code_fifo #(
        .WIDTH (`ENTRY_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .flush     (soft_rst),
        .in_valid  (push),
        .in_data   (push_entry),
        .in_ready  (),
        .out_valid (fifo_valid),
        .out_data  (head_entry),
        .out_ready (pop || drop),
        .count     (fifo_count),
        .full      (fifo_full)
    );

    // ----------------------------------------------------------------
    // access sequencer and registers
    // ----------------------------------------------------------------
    // next values for the whole block
    always_comb begin
        state_nxt     = state_r;
        pend_mask_nxt = pend_mask_r;
        pend_data_nxt = pend_data_r;
        size_nxt      = size_r;
        first_nxt     = first_r;
        snap_nxt      = snap_r;
        irq_en_nxt    = irq_en_r;
        thres_nxt     = thres_r;
        act0_nxt      = act0_r;
        act1_nxt      = act1_r;
        lane_nxt      = lane_r;
        rdata_nxt     = rdata_r;
        ready_nxt     = 1'b0;
        push          = 1'b0;
        pop           = 1'b0;
        soft_rst      = 1'b0;
        push_entry    = '0;
        case (state_r)
            post_code_pkg::ST_IDLE: begin
                if (bus_in.req) begin
                    // RQ15 one access at a time, held by wait states
                    ready_nxt = 1'b1;
                    state_nxt = post_code_pkg::ST_GAP;
                    rdata_nxt = 32'h0000_0000;
                    if (bus_in.wr) begin
                        case (bus_in.addr)
                            `OFS_HOST_DATA: begin
                                // RQ18 inactive base drops data silently
                                if (act0_r && (bus_in.be != 4'h0)) begin
                                    pend_mask_nxt = bus_in.be;
                                    pend_data_nxt = bus_in.wdata;
                                    size_nxt      = size_code(bus_in.be);
                                    first_nxt     = 1'b1;
                                    ready_nxt     = 1'b0;
                                    state_nxt     = post_code_pkg::ST_SPLIT;
                                    // RQ9 whole instruction into snapshot at once
                                    for (int i = 0; i < 4; i++) begin
                                        if (bus_in.be[i]) begin
                                            snap_nxt[8*i +: 8] = bus_in.wdata[8*i +: 8];
                                        end
                                    end
                                end
                            end
                            `OFS_HOST_ALIAS: begin
                                // RQ19 alias byte steered to chosen lane
                                if (act0_r && act1_r) begin
                                    pend_mask_nxt                = 4'h1 << lane_r;
                                    pend_data_nxt                = {4{bus_in.wdata[7:0]}};
                                    size_nxt                     = `LEN_BYTE;
                                    first_nxt                    = 1'b1;
                                    ready_nxt                    = 1'b0;
                                    state_nxt                    = post_code_pkg::ST_SPLIT;
                                    snap_nxt[8*lane_r +: 8]      = bus_in.wdata[7:0];
                                end
                            end
                            `OFS_EC_STATUS: begin
                                if (bus_in.be[`STAT_IE_LANE]) begin
                                    irq_en_nxt = bus_in.wdata[`STAT_IE_BIT];
                                end
                            end
                            `OFS_EC_CONFIG: begin
                                // RQ21 threshold stored as a raw count
                                thres_nxt = bus_in.wdata[`THRES_WIDTH-1:0];
                                // RQ12 soft reset request
                                soft_rst  = bus_in.wdata[`CFG_SOFT_RESET_BIT];
                            end
                            `OFS_CFG_ACTIVATE: begin
                                // RQ17 enable bits at offset 330h, RQ14 no flush here
                                if (bus_in.ld1) begin
                                    act1_nxt = bus_in.wdata[0];
                                end else begin
                                    act0_nxt = bus_in.wdata[0];
                                end
                            end
                            `OFS_CFG_LANE: begin
                                if (bus_in.ld1) begin
                                    lane_nxt = bus_in.wdata[1:0];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end else begin
                        case (bus_in.addr)
                            // RQ4 controller pops through value register
                            `OFS_EC_VALUE: begin
                                // RQ7 attributes beside value, RQ10 empty read harmless
                                rdata_nxt = {16'h0000, fifo_full, threshold_status, overrun_r, fifo_valid,
                                             head_entry.len, head_entry.lane, head_entry.value};
                                pop       = fifo_valid;
                            end
                            `OFS_EC_STATUS: begin
                                // RQ7 status and enable as one word
                                rdata_nxt = {10'h000, fifo_count, 7'h00, irq_en_r,
                                             4'h0, fifo_full, threshold_status, overrun_r, fifo_valid};
                            end
                            `OFS_EC_CONFIG: begin
                                rdata_nxt = {26'h000_0000, thres_r};
                            end
                            `OFS_EC_SNAPSHOT: begin
                                // RQ8 snapshot readable at any time
                                rdata_nxt = snap_r;
                            end
                            `OFS_CFG_ACTIVATE: begin
                                rdata_nxt = {31'h0000_0000, bus_in.ld1 ? act1_r : act0_r};
                            end
                            `OFS_CFG_LANE: begin
                                rdata_nxt = {30'h0000_0000, bus_in.ld1 ? lane_r : 2'h0};
                            end
                            // RQ3 host data and all else read as zero
                            default: begin
                                rdata_nxt = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            post_code_pkg::ST_SPLIT: begin
                if (pend_mask_r == 4'h0) begin
                    ready_nxt = 1'b1;
                    state_nxt = post_code_pkg::ST_GAP;
                end else begin
                    // RQ2 one byte per cycle, never stalled so drop cannot loop back
                    push             = 1'b1;
                    push_entry.value = pend_data_r[8*low_lane(pend_mask_r) +: 8];
                    push_entry.lane  = low_lane(pend_mask_r);
                    push_entry.len   = first_r ? size_r : `LEN_CONT;
                    pend_mask_nxt    = pend_mask_r & ~(4'h1 << low_lane(pend_mask_r));
                    first_nxt        = 1'b0;
                end
            end
            post_code_pkg::ST_GAP: begin
                state_nxt = post_code_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = post_code_pkg::ST_IDLE;
            end
        endcase
        // RQ6 overrun held until next pop, a new drop wins
        overrun_nxt = (overrun_r && !pop) || drop;
        // RQ11 interrupt gated by enable and base activate
        irq_nxt = threshold_status && irq_en_r && act0_r;
        // RQ12 local reset returns everything to defaults
        if (soft_rst) begin
            pend_mask_nxt = 4'h0;
            snap_nxt      = 32'h0000_0000;
            overrun_nxt   = 1'b0;
            irq_en_nxt    = 1'b0;
            thres_nxt     = `THRES_RESET;
            act0_nxt      = 1'b0;
            act1_nxt      = 1'b0;
            lane_nxt      = `LANE_RESET;
            irq_nxt       = 1'b0;
        end
    end

    // RQ16 all flops on sys_clk
    // RQ13 only the chip-wide reset reaches these flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r     <= post_code_pkg::ST_IDLE;
            pend_mask_r <= 4'h0;
            pend_data_r <= 32'h0000_0000;
            size_r      <= `LEN_BYTE;
            first_r     <= 1'b0;
            snap_r      <= 32'h0000_0000;
            overrun_r   <= 1'b0;
            irq_en_r    <= 1'b0;
            thres_r     <= `THRES_RESET;
            act0_r      <= 1'b0;
            act1_r      <= 1'b0;
            lane_r      <= `LANE_RESET;
            ready_r     <= 1'b0;
            rdata_r     <= 32'h0000_0000;
            irq_r       <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            pend_mask_r <= pend_mask_nxt;
            pend_data_r <= pend_data_nxt;
            size_r      <= size_nxt;
            first_r     <= first_nxt;
            snap_r      <= snap_nxt;
            overrun_r   <= overrun_nxt;
            irq_en_r    <= irq_en_nxt;
            thres_r     <= thres_nxt;
            act0_r      <= act0_nxt;
            act1_r      <= act1_nxt;
            lane_r      <= lane_nxt;
            ready_r     <= ready_nxt;
            rdata_r     <= rdata_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // outputs straight from flops
    assign bus_ready           = ready_r;
    assign bus_rdata           = rdata_r;
    assign threshold_interrupt = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_dword_accept;
        take && bus_in.wr && (bus_in.addr == `OFS_HOST_DATA) && act0_r && (bus_in.be == 4'hf);
    endsequence

    sequence s_four_bytes;
        push [*4] ##1 !push ##1 ready_r;
    endsequence

    chk_dword_split: assert property (s_dword_accept |=> s_four_bytes) // RQ2
        else $error("dword write not split into four bytes");

    chk_overrun_set: assert property (drop |=> overrun_r) // RQ5
        else $error("overrun not flagged on full write");

    chk_full_level: assert property (drop && !soft_rst |=> fifo_full) // RQ1
        else $error("store left full state after discard");

    chk_overrun_clear: assert property (pop && !drop |=> !overrun_r) // RQ6
        else $error("overrun not cleared by pop");

    chk_empty_read: assert property (take && !bus_in.wr && (bus_in.addr == `OFS_EC_VALUE) && !fifo_valid
                                     |=> (fifo_count == '0) && !bus_rdata[12]) // RQ10
        else $error("empty read moved store or flagged data");

    chk_host_read: assert property (take && !bus_in.wr && (bus_in.addr == `OFS_HOST_DATA)
                                    |=> ready_r && (bus_rdata == 32'h0000_0000)) // RQ3
        else $error("host data read not zero");

    chk_inactive_drop: assert property (take && bus_in.wr && (bus_in.addr == `OFS_HOST_DATA) && !act0_r
                                        |=> $stable(snap_r) && !push && ready_r) // RQ18
        else $error("write taken while base inactive");

    chk_snap_atomic: assert property (!$stable(snap_r) |-> $past(take && bus_in.wr) || $past(soft_rst)) // RQ9
        else $error("snapshot changed outside instruction accept");

    chk_irq_gate: assert property (threshold_interrupt == $past(threshold_status && irq_en_r && act0_r)
                                   || $past(soft_rst)) // RQ11
        else $error("interrupt not gated as configured");

    chk_soft_reset: assert property (soft_rst |=> (fifo_count == '0) && !act0_r && !overrun_r) // RQ12
        else $error("local reset left state behind");

endmodule

/* post_code_bus_master.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// host and firmware access model on the shared bus
// ----------------------------------------------------------------
module bus_master (
    // clock
    input  wire logic               sys_clk,
    // shared bus
    output post_code_pkg::bus_req_s bus_in,
    input  wire logic               bus_ready,
    input  wire logic [31:0]        bus_rdata
);
    initial bus_in = '0;

    task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] b,
                       input logic [31:0] d, output logic [31:0] q, input logic l = 1'b0);
        @(negedge sys_clk);
        bus_in = '{req: 1'b1, wr: w, ld1: l, addr: a, be: b, wdata: d};
        // a lost answer is left to the bench's cycle ceiling
        do @(negedge sys_clk); while (bus_ready !== 1'b1);
        q = bus_rdata;
        // hold through the edge that samples ready, then release with inverted leftovers
        @(negedge sys_clk);
        bus_in = '{req: 1'b0, wr: ~w, ld1: ~l, addr: ~a, be: ~b, wdata: ~d};
    endtask
endmodule

/* tb.sv */
`timescale 1ns/10ps

module tb;
    logic                    sys_clk;
    logic                    rst;
    post_code_pkg::bus_req_s bus_in;
    logic                    bus_ready;
    logic [31:0]             bus_rdata;
    logic                    threshold_interrupt;
    logic [31:0]             q;
    int                      err_count;
    int                      num_checks;
    int                      cyc;

    post_code_capture_port dut (.sys_clk(sys_clk), .rst(rst), .bus_in(bus_in), .bus_ready(bus_ready),
                                .bus_rdata(bus_rdata), .threshold_interrupt(threshold_interrupt));
    bus_master m (.sys_clk(sys_clk), .bus_in(bus_in), .bus_ready(bus_ready), .bus_rdata(bus_rdata));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic summarize;
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // defaults, and data writes dropped while inactive
    task automatic t_idle;
        m.acc(0, 12'h108, 4'hf, 0, q); chk(q, 32'h1);
        m.acc(0, 12'h330, 4'hf, 0, q); chk(q, 32'h0);
        m.acc(1, 12'h000, 4'hf, 32'hdeadbeef, q);
        m.acc(0, 12'h10c, 4'hf, 0, q); chk(q, 32'h0);
        m.acc(0, 12'h104, 4'hf, 0, q); chk(q, 32'h0);
    endtask

    // dword write split into bytes, popped in order
    task automatic t_dword;
        m.acc(1, 12'h330, 4'h1, 32'h1, q);
        m.acc(1, 12'h000, 4'hf, 32'h44332211, q);
        m.acc(0, 12'h000, 4'hf, 0, q); chk(q, 32'h0);
        m.acc(0, 12'h10c, 4'hf, 0, q); chk(q, 32'h44332211);
        m.acc(0, 12'h104, 4'hf, 0, q); chk(q, 32'h00040005);
        for (int i = 0; i < 4; i++) begin
            m.acc(0, 12'h100, 4'hf, 0, q);
            chk(q[12:0], {1'b1, (i == 0) ? 2'h2 : 2'h3, 2'(i), 8'(8'h11 * (i + 1))});
        end
        m.acc(0, 12'h100, 4'hf, 0, q); chk(q[12], 1'b0);
        chk(threshold_interrupt, 1'b0);
    endtask

    // overrun, interrupt gating, soft reset
    task automatic t_over;
        for (int i = 0; i < 33; i++) m.acc(1, 12'h000, 4'h1, 32'(i), q);
        m.acc(0, 12'h104, 4'hf, 0, q); chk(q, 32'h0020000f);
        m.acc(0, 12'h10c, 4'hf, 0, q); chk(q, 32'h44332220);
        m.acc(1, 12'h104, 4'h2, 32'h100, q); chk(threshold_interrupt, 1'b1);
        m.acc(0, 12'h100, 4'hf, 0, q); chk(q[13:0], 14'h3001);
        m.acc(0, 12'h100, 4'hf, 0, q); chk(q[13:0], 14'h1002);
        m.acc(1, 12'h330, 4'h1, 32'h0, q); chk(threshold_interrupt, 1'b0);
        m.acc(0, 12'h104, 4'hf, 0, q); chk(q, 32'h001e0105);
        m.acc(1, 12'h108, 4'h1, 32'h80, q);
        m.acc(0, 12'h104, 4'hf, 0, q); chk(q, 32'h0);
        m.acc(0, 12'h10c, 4'hf, 0, q); chk(q, 32'h0);
    endtask

    // alias lane steering, word write, threshold drain
    task automatic t_alias;
        m.acc(1, 12'h330, 4'h1, 32'h1, q);
        m.acc(1, 12'h330, 4'h1, 32'h1, q, 1'b1);
        m.acc(1, 12'h3f0, 4'h1, 32'h2, q, 1'b1);
        m.acc(0, 12'h3f0, 4'hf, 0, q, 1'b1); chk(q, 32'h2);
        m.acc(1, 12'h004, 4'h1, 32'ha5, q);
        m.acc(0, 12'h100, 4'hf, 0, q); chk(q[12:0], 13'h12a5);
        m.acc(1, 12'h108, 4'h1, 32'h2, q);
        m.acc(1, 12'h104, 4'h2, 32'h100, q);
        m.acc(1, 12'h000, 4'h6, 32'h00bbcc00, q); chk(threshold_interrupt, 1'b1);
        m.acc(0, 12'h10c, 4'hf, 0, q); chk(q, 32'h00bbcc00);
        m.acc(0, 12'h100, 4'hf, 0, q); chk(q[12:0], 13'h15cc);
        chk(threshold_interrupt, 1'b0);
        m.acc(0, 12'h100, 4'hf, 0, q); chk(q[12:0], 13'h1ebb);
    endtask

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end

    // main sequence
    initial begin
        rst = 1'b1;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_idle();
        t_dword();
        t_over();
        t_alias();
        summarize();
    end
endmodule
